// ---- rtl/csbio_pkg.sv ----
// Purpose: Shared constants and types for the bit-serial I/O execution block
// Assumes: 16-bit words, bit 0 is the most significant bit in numbering
// Notes: Timing counts are in processor clock cycles
package csbio_pkg;

	localparam int          CSBIO_CLK_MHZ      = 100;
	localparam logic [3:0]  CSBIO_EQUAL_BIT    = 4'h2;
	localparam logic [15:0] CSBIO_RET_OPCODE   = 16'h045B;
	localparam logic [3:0]  CSBIO_LINK_REG     = 4'hB;
	localparam logic [3:0]  CSBIO_BASE_REG     = 4'hC;
	localparam logic [4:0]  CSBIO_BYTE_MAX_LEN = 5'h08;
	localparam int          CSBIO_BASE_LSB     = 1;
	localparam int          CSBIO_BASE_W       = 12;
	localparam logic [2:0]  CSBIO_STROBE_DLY   = 3'h1;
	localparam logic [2:0]  CSBIO_STROBE_LEN   = 3'h1;
	localparam logic [2:0]  CSBIO_ADDR_HOLD    = 3'h2;
	// Input ops hold the address until the pin synchroniser has settled
	localparam logic [2:0]  CSBIO_IN_HOLD      = 3'h5;
	localparam logic [15:0] CSBIO_ST_RESET     = 16'h0000;
	localparam logic [15:0] CSBIO_PC_STEP      = 16'h0002;

	typedef enum logic [2:0] {
		CSBIO_OP_NONE     = 3'b000,
		CSBIO_OP_SET_ZERO = 3'b001,
		CSBIO_OP_SET_ONE  = 3'b010,
		CSBIO_OP_TST      = 3'b011,
		CSBIO_OP_LOAD     = 3'b100,
		CSBIO_OP_STORE    = 3'b101
	} csbio_op_t;

	typedef struct packed {
		csbio_op_t   op;
		logic [7:0]  disp;
		logic [15:0] base;
		logic [4:0]  count;
		logic [15:0] data;
	} csbio_req_t;

	typedef struct packed {
		logic [14:0] addr;
		logic        out_bit;
		logic        strobe;
		logic        active;
	} csbio_bus_t;

endpackage

// ---- rtl/csbio_addr_calc.sv ----
// Purpose: Forms a serial I/O bit address from base register and displacement
// Assumes: Displacement is zero for multibit transfers
// Notes: Purely combinational
`timescale 1ns/100ps
module csbio_addr_calc
	import csbio_pkg::*;
(
	input  wire logic [15:0] i_base,
	input  wire logic [7:0]  i_disp,
	input  wire logic [11:0] i_step,
	output logic      [14:0] o_addr
);
	logic [11:0] base_field;
	logic [11:0] disp_ext;

	always_comb begin
		base_field = i_base[CSBIO_BASE_LSB +: CSBIO_BASE_W]; // RL5
		disp_ext   = {{4{i_disp[7]}}, i_disp}; // RL4
		o_addr     = {3'h0, 12'(base_field + disp_ext + i_step)}; // RL12
	end
endmodule // csbio_addr_calc

// ---- rtl/csbio_branch_unit.sv ----
// Purpose: Equal-flag jumps and link-register return address
// Assumes: Program counter holds a byte address of the current instruction
// Notes: Combinational helper for the main block
`timescale 1ns/100ps
module csbio_branch_unit
	import csbio_pkg::*;
(
	input  wire logic        i_equal_flag,
	input  wire logic        i_jump_if_equal,
	input  wire logic        i_jump_if_not_equal,
	input  wire logic [15:0] i_pc,
	output logic             o_take,
	output logic      [15:0] o_link
);
	always_comb begin
		o_take = (i_jump_if_equal & i_equal_flag) | (i_jump_if_not_equal & ~i_equal_flag); // RL6 RL7
		o_link = 16'(i_pc + CSBIO_PC_STEP); // RL9
	end
endmodule // csbio_branch_unit

// ---- rtl/csbio_exec.sv ----
// Purpose: Executes single-bit and multibit serial I/O, flag jumps and link
// Assumes: Requests come from the same clock; peripherals answer in one cycle
// Notes: Serial input is a pin and passes four flip-flops
`timescale 1ns/100ps
// Function
// [RL1] A zero bit instruction drives zero on the output line while its address shows.
// [RL2] A one bit instruction drives one on the output line while its address shows.
// [RL3] A test bit instruction samples the input line into the status equal flag, bit 2.
// [RL4] The single operand is an eight-bit signed displacement, -128 to +127.
// [RL5] The address is the sign-extended displacement plus base register bits 3 to 14.
// [RL6] Jump on equal branches when the tested input was one.
// [RL7] Jump on not equal branches when the tested input was zero.
// [RL8] Multibit transfers of nine or more bits use the whole word.
// [RL9] Branch and link writes the next instruction address to register 11.
// [RL10] Opcode 045B decodes as an indirect branch through register 11.
// [RL11] Transfers of one to eight bits use only the left byte from its low bit.
// [RL12] The top three address lines stay zero during every serial I/O operation.
// [RL13] Output operations raise the strobe for two phases after address is valid.
// [RL14] Peripherals update only on address match with strobe and drive input when addressed.
module csbio_exec
	import csbio_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire csbio_req_t  i_req,
	input  wire logic        i_req_valid,
	input  wire logic        i_serial_io_in_line,
	input  wire logic [15:0] i_opcode,
	input  wire logic        i_opcode_valid,
	input  wire logic        i_jump_if_equal,
	input  wire logic        i_jump_if_not_equal,
	input  wire logic        i_branch_and_link,
	input  wire logic [15:0] i_pc,
	output csbio_bus_t       o_bus,
	output logic      [15:0] o_status,
	output logic      [15:0] o_load_data,
	output logic             o_done,
	output logic             o_busy,
	output logic             o_jump_taken,
	output logic             o_link_we,
	output logic      [3:0]  o_link_reg,
	output logic      [15:0] o_link_value,
	output logic             o_return_jump
);
	typedef enum logic [1:0] {
		CSBIO_ST_IDLE  = 2'b00,
		CSBIO_ST_ADDR  = 2'b01,
		CSBIO_ST_STRB  = 2'b10,
		CSBIO_ST_END   = 2'b11
	} csbio_state_t;

	function automatic logic is_output(input csbio_op_t op);
		is_output = (op == CSBIO_OP_SET_ZERO) || (op == CSBIO_OP_SET_ONE) || (op == CSBIO_OP_LOAD);
	endfunction

	function automatic logic is_multi(input csbio_op_t op);
		is_multi = (op == CSBIO_OP_LOAD) || (op == CSBIO_OP_STORE);
	endfunction

	// Pin synchroniser, three stages
	logic [2:0]   in_sync;
	logic [2:0]   next_in_sync;
	logic         in_level;
	logic         next_in_level;

	csbio_state_t state;
	csbio_state_t next_state;
	csbio_req_t   req;
	csbio_req_t   next_req;
	logic [2:0]   tick;
	logic [2:0]   next_tick;
	logic [4:0]   bit_idx;
	logic [4:0]   next_bit_idx;
	logic [15:0]  shreg;
	logic [15:0]  next_shreg;
	logic [15:0]  status;
	logic [15:0]  next_status;
	csbio_bus_t   bus;
	csbio_bus_t   next_bus;
	logic         done;
	logic         next_done;
	logic         jtake;
	logic         next_jtake;
	logic         link_we;
	logic         next_link_we;
	logic [15:0]  link_val;
	logic [15:0]  next_link_val;
	logic         ret_jump;
	logic         next_ret_jump;
	logic         busy;
	logic         next_busy;

	logic [14:0]  cur_addr;
	logic         take;
	logic [15:0]  link_calc;
	logic         word_mode;
	logic [4:0]   len;
	logic [3:0]   src_pos;
	logic [2:0]   hold_last;

	csbio_addr_calc u_addr (
		.i_base (req.base),
		.i_disp (is_multi(req.op) ? 8'h00 : req.disp),
		.i_step ({7'h00, bit_idx}),
		.o_addr (cur_addr)
	);

	csbio_branch_unit u_branch (
		.i_equal_flag        (status[15 - CSBIO_EQUAL_BIT]),
		.i_jump_if_equal     (i_jump_if_equal),
		.i_jump_if_not_equal (i_jump_if_not_equal),
		.i_pc   (i_pc),
		.o_take (take),
		.o_link (link_calc)
	);

	always_comb begin
		next_in_sync  = {in_sync[1:0], i_serial_io_in_line};
		next_in_level = (in_sync[2] == in_sync[1]) ? in_sync[2] : in_level;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			in_sync  <= 3'h0;
			in_level <= 1'b0;
		end else if (i_ce) begin
			in_sync  <= next_in_sync;
			in_level <= next_in_level;
		end
	end

	always_comb begin
		// Zero length means sixteen bits
		len       = (req.count == 5'h00) ? 5'h10 : req.count;
		word_mode = len > CSBIO_BYTE_MAX_LEN; // RL8
		// Left byte starts at its low end, position 8; a word at position 0
		src_pos   = word_mode ? bit_idx[3:0] : {1'b1, bit_idx[2:0]}; // RL8 RL11
		// Inputs wait out the pin synchroniser on each new address
		hold_last = is_output(req.op) ? CSBIO_ADDR_HOLD - 3'h1 : CSBIO_IN_HOLD - 3'h1; // RL3
	end

	always_comb begin
		next_state    = state;
		next_req      = req;
		next_tick     = tick;
		next_bit_idx  = bit_idx;
		next_shreg    = shreg;
		next_status   = status;
		next_bus      = bus;
		next_done     = 1'b0;
		next_jtake    = take; // RL6 RL7
		next_link_we  = 1'b0;
		next_link_val = link_val;
		next_ret_jump = 1'b0;
		if (i_branch_and_link) begin
			next_link_we  = 1'b1; // RL9
			next_link_val = link_calc; // RL9
		end
		if (i_opcode_valid && (i_opcode == CSBIO_RET_OPCODE)) begin
			next_ret_jump = 1'b1; // RL10
		end
		case (state)
			CSBIO_ST_IDLE: begin
				next_bus = '0;
				if (i_req_valid && (i_req.op != CSBIO_OP_NONE)) begin
					next_req     = i_req;
					next_bit_idx = 5'h00;
					next_tick    = 3'h0;
					next_shreg   = (i_req.op == CSBIO_OP_LOAD) ? i_req.data : 16'h0000;
					next_state   = CSBIO_ST_ADDR;
				end
			end
			CSBIO_ST_ADDR: begin
				next_bus.addr   = cur_addr; // RL5 RL12
				next_bus.active = 1'b1;
				case (req.op)
					CSBIO_OP_SET_ZERO: next_bus.out_bit = 1'b0; // RL1
					CSBIO_OP_SET_ONE: next_bus.out_bit = 1'b1; // RL2
					CSBIO_OP_LOAD: next_bus.out_bit = shreg[src_pos]; // RL11
					default: next_bus.out_bit = 1'b0;
				endcase
				next_tick  = 3'h0;
				next_state = CSBIO_ST_STRB;
			end
			CSBIO_ST_STRB: begin
				next_tick = 3'(tick + 3'h1);
				// Strobe one cycle after address, held one cycle (two phases)
				next_bus.strobe = is_output(req.op) && (tick == CSBIO_STROBE_DLY - 3'h1); // RL13
				if (tick == hold_last) begin
					next_bus.strobe = 1'b0;
					if (req.op == CSBIO_OP_TST) begin
						next_status[15 - CSBIO_EQUAL_BIT] = in_level; // RL3
					end
					if (req.op == CSBIO_OP_STORE) begin
						next_shreg[src_pos] = in_level; // RL8 RL11
					end
					if (is_multi(req.op) && (5'(bit_idx + 5'h01) < len)) begin
						next_bit_idx = 5'(bit_idx + 5'h01);
						next_state   = CSBIO_ST_ADDR;
					end else begin
						next_state = CSBIO_ST_END;
					end
				end
			end
			CSBIO_ST_END: begin
				next_bus   = '0;
				next_done  = 1'b1;
				next_state = CSBIO_ST_IDLE;
			end
			default: next_state = CSBIO_ST_IDLE;
		endcase
		next_busy = (next_state != CSBIO_ST_IDLE);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state    <= CSBIO_ST_IDLE;
			req      <= '0;
			tick     <= 3'h0;
			bit_idx  <= 5'h00;
			shreg    <= 16'h0000;
			status   <= CSBIO_ST_RESET;
			bus      <= '0;
			done     <= 1'b0;
			jtake    <= 1'b0;
			link_we  <= 1'b0;
			link_val <= 16'h0000;
			ret_jump <= 1'b0;
			busy     <= 1'b0;
		end else if (i_ce) begin
			state    <= next_state;
			req      <= next_req;
			tick     <= next_tick;
			bit_idx  <= next_bit_idx;
			shreg    <= next_shreg;
			status   <= next_status;
			bus      <= next_bus;
			done     <= next_done;
			jtake    <= next_jtake;
			link_we  <= next_link_we;
			link_val <= next_link_val;
			ret_jump <= next_ret_jump;
			busy     <= next_busy;
		end
	end

	// Registered outputs except the constant link register number; load data is the shift register after a store
	assign o_bus         = bus;
	assign o_status      = status;
	assign o_load_data   = shreg;
	assign o_done        = done;
	assign o_busy        = busy;
	assign o_jump_taken  = jtake;
	assign o_link_we     = link_we;
	assign o_link_reg    = CSBIO_LINK_REG;
	assign o_link_value  = link_val;
	assign o_return_jump = ret_jump;

	// Assertions
	sequence addr_phase_s;
		state == CSBIO_ST_ADDR;
	endsequence

	sequence strobe_pulse_s;
		!bus.strobe ##1 bus.strobe ##1 !bus.strobe;
	endsequence

	zero_out_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL1
		(bus.active && req.op == CSBIO_OP_SET_ZERO) |-> !bus.out_bit)
		else $error("zero bit drove one");

	one_out_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL2
		(bus.active && req.op == CSBIO_OP_SET_ONE) |-> bus.out_bit)
		else $error("one bit drove zero");

	test_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL3
		(i_ce && state == CSBIO_ST_STRB && tick == CSBIO_IN_HOLD - 3'h1 && req.op == CSBIO_OP_TST)
		|=> status[13] == $past(in_level))
		else $error("equal flag not from input");

	addr_top_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL12
		bus.addr[14:12] == 3'h0)
		else $error("top address lines not zero");

	strobe_output_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL13
		(addr_phase_s ##0 (i_ce && is_output(req.op)) ##1 (i_ce && state == CSBIO_ST_STRB))
		|-> strobe_pulse_s)
		else $error("strobe timing wrong");

	no_strobe_in_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL13
		bus.strobe |-> is_output(req.op))
		else $error("strobe on input op");

	jump_equal_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL6
		(i_ce && i_jump_if_equal && status[13]) |=> jtake)
		else $error("jump on equal missed");

	jump_noteq_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL7
		(i_ce && i_jump_if_not_equal && !i_jump_if_equal && !status[13]) |=> jtake)
		else $error("jump on not equal missed");

	link_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL9
		(i_ce && i_branch_and_link) |=> (link_we && link_val == $past(i_pc) + 16'h0002))
		else $error("link value wrong");

	return_decode_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // RL10
		(i_ce && i_opcode_valid && i_opcode == 16'h045B) |=> ret_jump)
		else $error("return opcode not decoded");
endmodule // csbio_exec

// ---- verification/csbio_periph_model.sv ----
// Purpose: Bit-addressed peripheral model on the serial I/O bus
// Assumes: One storage bit per bit address, whole 12-bit space
// Notes: Input pin follows a preselected address between operations,
// Notes: because the pin passes a slow synchroniser in the block
`timescale 1ns/100ps
module csbio_periph_model
	import csbio_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire csbio_bus_t  i_bus,
	input  wire logic [11:0] i_preselect,
	output logic             o_in_line
);
	logic mem [0:4095];

	initial begin
		for (int k = 0; k < 4096; k++) mem[k] = 1'b0;
	end

	// Update only when addressed and strobed
	always @(posedge i_core_clk) begin
		if (i_bus.active === 1'b1 && i_bus.strobe === 1'b1) begin
			mem[i_bus.addr[11:0]] <= i_bus.out_bit;
		end
	end

	assign o_in_line = i_bus.active ? mem[i_bus.addr[11:0]] : mem[i_preselect];
endmodule // csbio_periph_model

// ---- verification/csbio_exec_tb.sv ----
// Purpose: Self-checking bench for the serial I/O execution block
// Assumes: Clock enable stays high throughout
// Notes: Stores read back the loaded pattern, so bit order is checked both ways
`timescale 1ns/100ps
module csbio_exec_tb;
	import csbio_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	logic        opv = 1'b0;
	logic        jump_equal = 1'b0;
	logic        jump_not_equal = 1'b0;
	logic        link_call = 1'b0;
	csbio_req_t  req = '0;
	logic [15:0] opcode = 16'h0000;
	logic [15:0] pc = 16'h0000;
	logic [11:0] pre = 12'h000;
	logic [15:0] pat = 16'hA5C3;
	logic        in_line;
	csbio_bus_t  bus;
	logic [15:0] o_status;
	logic [15:0] o_load_data;
	logic        o_done;
	logic        o_jump_taken;
	logic        o_link_we;
	logic [3:0]  o_link_reg;
	logic [15:0] o_link_value;
	logic        o_return_jump;
	int          bad_count = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	csbio_exec i_csbio_exec (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_req(req),
		.i_req_valid(req_valid), .i_serial_io_in_line(in_line), .i_opcode(opcode),
		.i_opcode_valid(opv), .i_jump_if_equal(jump_equal),
		.i_jump_if_not_equal(jump_not_equal),
		.i_branch_and_link(link_call), .i_pc(pc), .o_bus(bus), .o_status(o_status),
		.o_load_data(o_load_data), .o_done(o_done), .o_busy(), .o_jump_taken(o_jump_taken),
		.o_link_we(o_link_we), .o_link_reg(o_link_reg), .o_link_value(o_link_value),
		.o_return_jump(o_return_jump));

	csbio_periph_model i_csbio_periph_model (.i_core_clk(clk), .i_bus(bus),
		.i_preselect(pre), .o_in_line(in_line));

	task automatic results;
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One request; first address, output bit and strobe count judged on the way
	task automatic run(input csbio_op_t op, input logic [7:0] disp, input logic [15:0] base,
		input logic [4:0] cnt, input logic [15:0] data, input logic [4:0] nstb);
		int         n;
		logic [4:0] sc;
		logic       first;
		logic [11:0] ea;
		n = 0;
		sc = 5'h00;
		first = 1'b1;
		ea = base[12:1] + {{4{disp[7]}}, disp};
		@(posedge clk);
		req <= '{op: op, disp: disp, base: base, count: cnt, data: data};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		while (o_done !== 1'b1) begin
			if (bus.active === 1'b1 && first) begin
				first = 1'b0;
				check("addr", 16'(bus.addr), {4'h0, ea});
				if (op == CSBIO_OP_SET_ZERO || op == CSBIO_OP_SET_ONE)
					check("out_bit", 16'(bus.out_bit), 16'(op == CSBIO_OP_SET_ONE));
			end
			sc = sc + 5'(bus.strobe === 1'b1);
			@(posedge clk);
			#1;
			n++;
			if (n > 200) begin
				check("timeout", 16'h0000, 16'h0001);
				results();
			end
		end
		if (op != CSBIO_OP_TST && op != CSBIO_OP_STORE)
			check("strobes", 16'(sc), 16'(nstb));
	endtask

	task automatic jump(input logic e, input logic ne, input logic exp);
		@(posedge clk);
		jump_equal <= e;
		jump_not_equal <= ne;
		@(posedge clk);
		#1;
		check("jump_taken", 16'(o_jump_taken), 16'(exp));
		@(posedge clk);
		jump_equal <= 1'b0;
		jump_not_equal <= 1'b0;
	endtask

	// Set a bit, read it back, then both conditional jumps
	task automatic test_bit(input csbio_op_t setop, input logic exp);
		run(setop, 8'h05, 16'h0200, 5'h00, 16'h0000, 5'h01);
		repeat (5) @(posedge clk);
		run(CSBIO_OP_TST, 8'h05, 16'h0200, 5'h00, 16'h0000, 5'h00);
		check("equal_flag", 16'(o_status[13]), 16'(exp));
		jump(1'b1, 1'b0, exp);
		jump(1'b0, 1'b1, !exp);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("link_reg", 16'(o_link_reg), 16'h000B);
		run(CSBIO_OP_SET_ONE, 8'h80, 16'h0100, 5'h00, 16'h0000, 5'h01);
		check("mem_lo", 16'(i_csbio_periph_model.mem[12'h000]), 16'h0001);
		run(CSBIO_OP_SET_ONE, 8'h7F, 16'h8101, 5'h00, 16'h0000, 5'h01);
		check("mem_set", 16'(i_csbio_periph_model.mem[12'h0FF]), 16'h0001);
		run(CSBIO_OP_SET_ZERO, 8'h7F, 16'h8101, 5'h00, 16'h0000, 5'h01);
		check("mem_hi", 16'(i_csbio_periph_model.mem[12'h0FF]), 16'h0000);
		test_bit(CSBIO_OP_SET_ONE, 1'b1);
		test_bit(CSBIO_OP_SET_ZERO, 1'b0);
		run(CSBIO_OP_LOAD, 8'h00, 16'h0400, 5'h00, pat, 5'h10);
		for (int k = 0; k < 16; k++)
			check("word_bit", 16'(i_csbio_periph_model.mem[12'h200 + k]), 16'(pat[k]));
		run(CSBIO_OP_LOAD, 8'h00, 16'h0600, 5'h02, 16'h0100, 5'h02);
		check("byte_b0", 16'(i_csbio_periph_model.mem[12'h300]), 16'h0001);
		check("byte_b1", 16'(i_csbio_periph_model.mem[12'h301]), 16'h0000);
		run(CSBIO_OP_LOAD, 8'h00, 16'h0800, 5'h00, 16'hFFFF, 5'h10);
		pre <= 12'h400;
		repeat (5) @(posedge clk);
		run(CSBIO_OP_STORE, 8'h00, 16'h0400, 5'h03, 16'h0000, 5'h00);
		check("store_byte", o_load_data, {5'h00, pat[2:0], 8'h00});
		run(CSBIO_OP_STORE, 8'h00, 16'h0400, 5'h09, 16'h0000, 5'h00);
		check("store_word", o_load_data, {7'h00, pat[8:0]});
		@(posedge clk);
		link_call <= 1'b1;
		pc <= 16'h0012;
		@(posedge clk);
		link_call <= 1'b0;
		#1;
		check("link_we", 16'(o_link_we), 16'h0001);
		check("link_value", o_link_value, 16'h0014);
		@(posedge clk);
		opcode <= CSBIO_RET_OPCODE;
		opv <= 1'b1;
		@(posedge clk);
		opcode <= 16'h045A;
		#1;
		check("return_jump", 16'(o_return_jump), 16'h0001);
		@(posedge clk);
		#1;
		check("no_return", 16'(o_return_jump), 16'h0000);
		results();
	end
endmodule // csbio_exec_tb
